// ### rtl/root_port_enum_sequencer.v
// Purpose: Enumeration sequencer plus BAR test master for a root port
// Assumes: One clock; root port transmit and receive streams, 64 bits
// Notes:   Receive side is never throttled
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "enum_map.vh"

// Functional notes
// - Read ROM entries in order, build each TLP and transmit it.
// - Only message, message with data, config write and read Type 0.
// - After a config request, wait for its completion before continuing.
// - Mismatching completion header fields fail the enumeration.
// - Completion payload of config requests is never compared.
// - No completion timer; waiting lasts forever without error.
// - Build option adds one register stage on the receive stream.
// - Parameter gives populated ROM lines, two per TLP; stop after them.
// - Every request carries the SOURCE_ID from a parameter.
// - Sequencer owns stream during enumeration, then the BAR test master uses it.
// - At end raise done; on failure also raise fail.
// - If speed cap allows, request 2.5 to 5.0 Gb/s change first.
// - Header word at even address, 32-bit payload at next odd one.
// - Unused payload word for reads and plain messages is skipped.
// - Two-bit type; message routing and code; config function, reg, BE.
// - Test master waits for link up, then pulses begin.
// - After done, write and read back each BAR; all match gives pass.
// - Test fails on readback mismatch or enumeration failure.
// - One-cycle restart pulse reruns the test sequence.
// - Test master requests and completions carry exactly one dword.
module root_port_enum_sequencer #(
  parameter        RX_PIPE   = 0,
  parameter        ROM_LINES = `DEF_ROM_LINES,
  parameter [15:0] SOURCE_ID = `DEF_SOURCE_ID,
  parameter        TOP_SPEED = `DEF_TOP_SPEED
) (
  input  wire        clk,            // User clock, 100 MHz
  input  wire        rst,            // Synchronous reset, active high
  input  wire        link_up,        // Root port link up
  input  wire        restart,        // Test restart pulse
  input  wire        speed_done,     // Speed change finished pulse
  output reg         speed_req,      // Speed change request level
  output reg         tx_tvalid,      // Transmit stream valid
  input  wire        tx_tready,      // Transmit stream ready
  output reg  [63:0] tx_tdata,       // Transmit stream data
  output reg  [7:0]  tx_tkeep,       // Transmit byte keep
  output reg         tx_tlast,       // Transmit last beat
  input  wire        rx_tvalid,      // Receive stream valid
  input  wire [63:0] rx_tdata,       // Receive stream data
  input  wire [7:0]  rx_tkeep,       // Receive byte keep
  input  wire        rx_tlast,       // Receive last beat
  output reg         enum_done,      // Enumeration finished
  output reg         enum_fail,      // Enumeration failed
  output reg         test_passed,    // BAR test passed
  output reg         test_failed,    // BAR test failed
  input  wire [3:0]  reg_addr,       // Register byte address
  input  wire [31:0] reg_wdata,      // Register write data
  input  wire        reg_wr,         // Register write strobe
  input  wire        reg_rd,         // Register read strobe
  output reg  [31:0] reg_rdata       // Read data, cycle after strobe
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_BEGIN = 4'h1;
  localparam [3:0] S_SPEED = 4'h2;
  localparam [3:0] S_FETCH = 4'h3;
  localparam [3:0] S_SEND  = 4'h4;
  localparam [3:0] S_WAIT  = 4'h5;
  localparam [3:0] S_CEND  = 4'h6;
  localparam [3:0] S_TLOAD = 4'h7;
  localparam [3:0] S_TEND  = 4'h8;

  reg  [3:0]  state;
  reg  [4:0]  rom_ptr;
  reg         begin_pulse;
  reg         auto_start;
  reg  [7:0]  tag;
  reg  [31:0] h0;
  reg  [31:0] h1;
  reg  [31:0] h2;
  reg  [31:0] h3;
  reg  [31:0] pl;
  reg         has_data;
  reg         four_dw;
  reg  [1:0]  beat_idx;
  reg         need_cpl;
  reg         test_phase;
  reg         test_rd;
  reg  [3:0]  bar_idx;
  reg         cpl_first;
  reg         cpl_ok;
  reg  [6:0]  cpl_kind;
  reg  [63:0] nb_data;
  reg  [7:0]  nb_keep;
  reg         nb_last;
  reg         p_valid;
  reg  [63:0] p_data;
  reg  [7:0]  p_keep;
  reg         p_last;
  wire        r_valid;
  wire [63:0] r_data;
  wire        r_last;
  wire [31:0] hdr_w;
  wire [31:0] pay_w;
  wire [1:0]  kind;
  wire [31:0] bar_addr;
  wire [31:0] pattern;
  wire        sw_restart;

  // ==========================================================
  // Configuration ROM
  function [31:0] rom_word;
    input [4:0] idx;
    begin
      case (idx)
        5'h00:   rom_word = 32'h80010F00;
        5'h01:   rom_word = `BAR0_ADDR;
        5'h02:   rom_word = 32'h80004F00;
        5'h03:   rom_word = 32'h00000006;
        5'h04:   rom_word = 32'hC0000F00;
        5'h05:   rom_word = 32'h00000000;
        5'h06:   rom_word = 32'h20000050;
        5'h07:   rom_word = 32'h00000000;
        default: rom_word = 32'h00000000;
      endcase
    end
  endfunction

  assign hdr_w = rom_word(rom_ptr);
  assign pay_w = rom_word(rom_ptr + 5'h01);
  assign kind  = hdr_w[`ROM_TYPE_HI:`ROM_TYPE_LO];
  assign bar_addr = `BAR0_ADDR + ({28'h0, bar_idx} << `BAR_STRIDE_SHIFT);
  assign pattern  = `TEST_PATTERN | {28'h0, bar_idx};
  assign sw_restart = reg_wr && (reg_addr == `ENUM_REG_CTRL)
                      && reg_wdata[`ENUM_CTRL_RESTART];

  // ==========================================================
  // Optional receive register stage
  always @(posedge clk) begin
    if (rst) begin
      p_valid <= 1'b0;
      p_data  <= 64'h0;
      p_keep  <= 8'h00;
      p_last  <= 1'b0;
    end else begin
      p_valid <= rx_tvalid;
      p_data  <= rx_tdata;
      p_keep  <= rx_tkeep;
      p_last  <= rx_tlast;
    end
  end

  assign r_valid = (RX_PIPE != 0) ? p_valid : rx_tvalid;
  assign r_data  = (RX_PIPE != 0) ? p_data  : rx_tdata;
  assign r_last  = (RX_PIPE != 0) ? p_last  : rx_tlast;

  // ==========================================================
  // Beat builder: 3DW header plus payload, or 4DW message
  always @* begin
    nb_data = {h1, h0};
    nb_keep = `KEEP_FULL;
    nb_last = 1'b0;
    case (beat_idx)
      2'h0: begin
        nb_data = {h1, h0};
      end
      2'h1: begin
        if (four_dw) begin
          nb_data = {h3, h2};
          nb_last = !has_data;
        end else begin
          nb_data = {pl, h2};
          nb_keep = has_data ? `KEEP_FULL : `KEEP_LOW;
          nb_last = 1'b1;
        end
      end
      default: begin
        nb_data = {32'h0, pl};
        nb_keep = `KEEP_LOW;
        nb_last = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Sequencer and test master
  always @(posedge clk) begin
    if (rst) begin
      state       <= S_IDLE;
      rom_ptr     <= 5'h00;
      begin_pulse <= 1'b0;
      tag         <= 8'h00;
      h0          <= 32'h0;
      h1          <= 32'h0;
      h2          <= 32'h0;
      h3          <= 32'h0;
      pl          <= 32'h0;
      has_data    <= 1'b0;
      four_dw     <= 1'b0;
      beat_idx    <= 2'h0;
      need_cpl    <= 1'b0;
      test_phase  <= 1'b0;
      test_rd     <= 1'b0;
      bar_idx     <= 4'h0;
      cpl_first   <= 1'b1;
      cpl_ok      <= 1'b1;
      cpl_kind    <= 7'h00;
      speed_req   <= 1'b0;
      tx_tvalid   <= 1'b0;
      tx_tdata    <= 64'h0;
      tx_tkeep    <= 8'h00;
      tx_tlast    <= 1'b0;
      enum_done   <= 1'b0;
      enum_fail   <= 1'b0;
      test_passed <= 1'b0;
      test_failed <= 1'b0;
    end else begin
      begin_pulse <= 1'b0;
      if ((restart || sw_restart) && enum_done && !tx_tvalid) begin
        state       <= S_CEND;
        test_passed <= 1'b0;
        test_failed <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (link_up && auto_start) begin
              begin_pulse <= 1'b1;
              state       <= S_BEGIN;
            end
          end
          S_BEGIN: begin
            if (begin_pulse) begin
              if (TOP_SPEED >= `SPEED_GEN2) begin
                speed_req <= 1'b1;
                state     <= S_SPEED;
              end else begin
                state <= S_FETCH;
              end
            end
          end
          S_SPEED: begin
            if (speed_done) begin
              speed_req <= 1'b0;
              state     <= S_FETCH;
            end
          end
          S_FETCH: begin
            if ({27'h0, rom_ptr} >= ROM_LINES) begin
              state <= S_CEND;
            end else begin
              rom_ptr  <= rom_ptr + 5'h02;
              tag      <= tag + 8'h01;
              pl       <= pay_w;
              beat_idx <= 2'h0;
              h1 <= {SOURCE_ID, tag, 4'h0,
                     hdr_w[`ROM_BE_HI:`ROM_BE_LO]};
              h2 <= {`TGT_BUS, `TGT_DEV,
                     hdr_w[`ROM_FUNC_HI:`ROM_FUNC_LO], 4'h0,
                     hdr_w[`ROM_REG_HI:`ROM_REG_LO], 2'h0};
              h3 <= 32'h0;
              state <= S_SEND;
              case (kind)
                `KIND_CFG_WR: begin
                  h0       <= `HDR_CFG_WR;
                  has_data <= 1'b1;
                  four_dw  <= 1'b0;
                  need_cpl <= 1'b1;
                  cpl_kind <= `CPL_FMT_TYPE;
                end
                `KIND_CFG_RD: begin
                  h0       <= `HDR_CFG_RD;
                  has_data <= 1'b0;
                  four_dw  <= 1'b0;
                  need_cpl <= 1'b1;
                  cpl_kind <= `CPLD_FMT_TYPE;
                end
                default: begin
                  h0 <= (kind == `KIND_MSG_DATA) ? `HDR_MSG_DATA
                        : `HDR_MSG;
                  h0[26:24] <= hdr_w[`ROM_ROUTE_HI:`ROM_ROUTE_LO];
                  h1 <= {SOURCE_ID, tag,
                         hdr_w[`ROM_CODE_HI:`ROM_CODE_LO]};
                  h2 <= 32'h0;
                  has_data <= (kind == `KIND_MSG_DATA);
                  four_dw  <= 1'b1;
                  need_cpl <= 1'b0;
                end
              endcase
            end
          end
          S_SEND: begin
            if (tx_tvalid && tx_tready && tx_tlast) begin
              tx_tvalid <= 1'b0;
              cpl_first <= 1'b1;
              cpl_ok    <= 1'b1;
              if (need_cpl) begin
                state <= S_WAIT;
              end else begin
                state <= test_phase ? S_TLOAD : S_FETCH;
              end
            end else if (!tx_tvalid || tx_tready) begin
              tx_tvalid <= 1'b1;
              tx_tdata  <= nb_data;
              tx_tkeep  <= nb_keep;
              tx_tlast  <= nb_last;
              beat_idx  <= beat_idx + 2'h1;
            end
          end
          S_WAIT: begin
            // Waits with no timer for the completion
            if (r_valid) begin
              if (cpl_first) begin
                cpl_first <= 1'b0;
                if (r_data[30:24] != cpl_kind ||
                    r_data[47:45] != `CPL_STATUS_OK ||
                    r_last)
                  cpl_ok <= 1'b0;
                if (r_last) begin
                  state <= test_phase ? S_TEND : S_CEND;
                  if (test_phase)
                    test_failed <= 1'b1;
                  else
                    {enum_done, enum_fail} <= 2'b11;
                end
              end else begin
                if (test_phase) begin
                  if (!cpl_ok || r_data[63:32] != pattern) begin
                    test_failed <= 1'b1;
                    state       <= S_TEND;
                  end else begin
                    bar_idx <= bar_idx + 4'h1;
                    test_rd <= 1'b0;
                    state   <= S_TLOAD;
                  end
                end else if (!cpl_ok ||
                             r_data[31:16] != SOURCE_ID ||
                             r_data[15:8] != h1[15:8]) begin
                  {enum_done, enum_fail} <= 2'b11;
                  state     <= S_CEND;
                end else begin
                  state <= S_FETCH;
                end
              end
            end
          end
          S_CEND: begin
            enum_done  <= 1'b1;
            test_phase <= 1'b1;
            bar_idx    <= 4'h0;
            test_rd    <= 1'b0;
            if (enum_fail) begin
              test_failed <= 1'b1;
              state       <= S_TEND;
            end else begin
              state <= S_TLOAD;
            end
          end
          S_TLOAD: begin
            if (bar_idx == `TEST_BARS) begin
              test_passed <= 1'b1;
              state       <= S_TEND;
            end else begin
              tag      <= tag + 8'h01;
              h0       <= test_rd ? `HDR_MEM_RD : `HDR_MEM_WR;
              h1       <= {SOURCE_ID, tag, `MEM_BE};
              h2       <= bar_addr;
              h3       <= 32'h0;
              pl       <= pattern;
              has_data <= !test_rd;
              four_dw  <= 1'b0;
              need_cpl <= test_rd;
              cpl_kind <= `CPLD_FMT_TYPE;
              beat_idx <= 2'h0;
              test_rd  <= 1'b1;
              state    <= S_SEND;
            end
          end
          S_TEND: begin
            state <= S_TEND;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register port
  always @(posedge clk) begin
    if (rst) begin
      auto_start <= `ENUM_CTRL_RESET;
      reg_rdata  <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `ENUM_REG_CTRL)
        auto_start <= reg_wdata[`ENUM_CTRL_AUTO];
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `ENUM_REG_CTRL: reg_rdata <= {31'h0, auto_start};
          `ENUM_REG_STAT: reg_rdata <= {20'h0, state, 3'h0, speed_req,
                                        test_passed, test_failed,
                                        enum_fail, enum_done};
          default:        reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/enum_map.vh
// Purpose: Constants for the root port enumeration sequencer
// Assumes: 64-bit transmit and receive streams, 32-bit register port
// Notes:   Included by the sequencer and its testbench
`ifndef ENUM_MAP_VH
`define ENUM_MAP_VH

// ==========================================================
// Register map
`define ENUM_REG_CTRL       4'h0
`define ENUM_REG_STAT       4'h4
`define ENUM_CTRL_RESET     1'b1
`define ENUM_CTRL_AUTO      0
`define ENUM_CTRL_RESTART   1
`define ENUM_STAT_DONE      0
`define ENUM_STAT_FAIL      1
`define ENUM_STAT_TFAIL     2
`define ENUM_STAT_TPASS     3
`define ENUM_STAT_SPEED     4

// ==========================================================
// ROM header word fields
`define ROM_TYPE_HI         31
`define ROM_TYPE_LO         30
`define ROM_ROUTE_HI        29
`define ROM_ROUTE_LO        27
`define ROM_FUNC_HI         26
`define ROM_FUNC_LO         24
`define ROM_REG_HI          23
`define ROM_REG_LO          14
`define ROM_BE_HI           11
`define ROM_BE_LO           8
`define ROM_CODE_HI         7
`define ROM_CODE_LO         0
`define KIND_MSG            2'h0
`define KIND_MSG_DATA       2'h1
`define KIND_CFG_WR         2'h2
`define KIND_CFG_RD         2'h3

// ==========================================================
// TLP first dwords and fields
`define HDR_CFG_RD          32'h04000001
`define HDR_CFG_WR          32'h44000001
`define HDR_MSG             32'h30000000
`define HDR_MSG_DATA        32'h70000001
`define HDR_MEM_WR          32'h40000001
`define HDR_MEM_RD          32'h00000001
`define CPL_FMT_TYPE        7'h0A
`define CPLD_FMT_TYPE       7'h4A
`define CPL_STATUS_OK       3'h0
`define TGT_BUS             8'h01
`define TGT_DEV             5'h00
`define MEM_BE              8'h0F
`define KEEP_FULL           8'hFF
`define KEEP_LOW            8'h0F

// ==========================================================
// Defaults
`define DEF_SOURCE_ID       16'h0100
`define DEF_ROM_LINES       8
`define DEF_TOP_SPEED       2
`define SPEED_GEN2          2
`define TEST_BARS           4'h1
`define BAR0_ADDR           32'h10000000
`define BAR_STRIDE_SHIFT    12
`define TEST_PATTERN        32'hA5A50000

`endif

// ### verif/enum_seq_checker_asserts.sv
// Purpose: Port assertions for the enumeration sequencer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module enum_seq_checker (
  input wire logic        clk,         // Clock
  input wire logic        rst,         // Reset
  input wire logic        link_up,     // Link up
  input wire logic        speed_req,   // Speed request
  input wire logic        speed_done,  // Speed change done
  input wire logic        tx_tvalid,   // Transmit valid
  input wire logic        tx_tready,   // Transmit ready
  input wire logic [63:0] tx_tdata,    // Transmit data
  input wire logic [7:0]  tx_tkeep,    // Transmit keep
  input wire logic        tx_tlast,    // Transmit last
  input wire logic        enum_done,   // Enumeration done
  input wire logic        enum_fail,   // Enumeration failed
  input wire logic        test_passed, // Test passed
  input wire logic        test_failed  // Test failed
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tx_hold;
    tx_tvalid && !tx_tready |=> tx_tvalid && $stable(tx_tdata)
      && $stable(tx_tkeep) && $stable(tx_tlast);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit beat changed while stalled");

  property p_speed_first;
    speed_req |-> !tx_tvalid;
  endproperty
  a_speed_first: assert property (p_speed_first)
    else $error("traffic sent during speed change");

  property p_speed_end;
    speed_req && speed_done |=> !speed_req;
  endproperty
  a_speed_end: assert property (p_speed_end)
    else $error("speed request held after completion");

  property p_wait_link;
    !link_up && !enum_done |-> !tx_tvalid && !speed_req;
  endproperty
  a_wait_link: assert property (p_wait_link)
    else $error("activity before link up");

  property p_fail_done;
    enum_fail |-> enum_done;
  endproperty
  a_fail_done: assert property (p_fail_done)
    else $error("fail without done");

  property p_done_hold;
    enum_done |=> enum_done && $stable(enum_fail);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done or fail changed before reset");

  property p_pass_ok;
    test_passed |-> enum_done && !enum_fail && !test_failed;
  endproperty
  a_pass_ok: assert property (p_pass_ok)
    else $error("pass without clean enumeration");

  property p_fail_report;
    $rose(enum_fail) |-> ##[0:8] test_failed;
  endproperty
  a_fail_report: assert property (p_fail_report)
    else $error("enumeration failure not reported by test");

  property p_no_early;
    !enum_done |-> !test_passed && !test_failed;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("test verdict before enumeration end");

  property p_keep;
    tx_tvalid && tx_tlast |-> tx_tkeep == 8'hFF || tx_tkeep == 8'h0F;
  endproperty
  a_keep: assert property (p_keep)
    else $error("last beat keep is not whole dwords");
endmodule

bind root_port_enum_sequencer enum_seq_checker u_chk (
  .clk(clk), .rst(rst), .link_up(link_up), .speed_req(speed_req),
  .speed_done(speed_done), .tx_tvalid(tx_tvalid), .tx_tready(tx_tready),
  .tx_tdata(tx_tdata), .tx_tkeep(tx_tkeep), .tx_tlast(tx_tlast),
  .enum_done(enum_done), .enum_fail(enum_fail),
  .test_passed(test_passed), .test_failed(test_failed));
`default_nettype wire

// ### verif/root_port_model.sv
// Purpose: Behavioural root port transaction side
// Assumes: Completions are two 64-bit beats
// Notes:   Knobs delay and corrupt the answers; requests stall at random
`timescale 1ns/1ns
`default_nettype none
module root_port_model (
  input  wire logic        clk,        // Clock
  input  wire logic        rst,        // Reset
  input  wire logic        tx_tvalid,  // Request valid
  output var  logic        tx_tready,  // Request ready
  input  wire logic [63:0] tx_tdata,   // Request data
  input  wire logic        tx_tlast,   // Request last
  output var  logic        rx_tvalid,  // Completion valid
  output var  logic [63:0] rx_tdata,   // Completion data
  output var  logic [7:0]  rx_tkeep,   // Completion keep
  output var  logic        rx_tlast,   // Completion last
  input  wire logic        speed_req,  // Speed request
  output wire logic        speed_done, // Speed change done
  input  wire logic        bad_status, // Error status in answers
  input  wire logic        bad_data,   // Corrupt memory read data
  input  wire logic [9:0]  cpl_delay   // Cycles before an answer
);
  logic [62:0] pend[$];
  logic [62:0] c;
  logic [31:0] dw0, mem, seed;
  logic [23:0] rt;
  logic        first;
  logic [4:0]  sp_cnt;
  // ==========================================================
  // Request capture, random stalls
  always @(posedge clk) begin
    tx_tready <= !rst && ($random(seed) % 4 != 0);
    if (rst) begin
      first <= 1'b1;
      pend.delete();
    end else if (tx_tvalid && tx_tready) begin
      first <= tx_tlast;
      if (first) begin
        dw0 <= tx_tdata[31:0];
        rt  <= tx_tdata[63:40];
      end else if (tx_tlast) begin
        case (dw0[30:24])
          7'h44: pend.push_back({7'h0A, rt, 32'h0});
          7'h04: pend.push_back({7'h4A, rt, seed});
          7'h00: pend.push_back({7'h4A, rt, mem ^ {31'h0, bad_data}});
          7'h40: mem <= tx_tdata[63:32];
          default: ;
        endcase
      end
    end
  end
  // ==========================================================
  // Completion sender, never waits for a ready
  initial begin
    seed = 32'hD399;
    rx_tvalid = 1'b0;
    rx_tlast = 1'b0;
    rx_tkeep = 8'h00;
    rx_tdata = 64'h0;
    forever begin
      @(posedge clk);
      if (!rst && pend.size() > 0) begin
        c = pend.pop_front();
        repeat (cpl_delay) @(posedge clk);
        rx_tvalid <= 1'b1;
        rx_tkeep  <= 8'hFF;
        rx_tdata  <= {16'h0, bad_status, 15'h4, 1'b0, c[62:56], 24'h1};
        @(posedge clk);
        rx_tlast <= 1'b1;
        rx_tdata <= {c[31:0], c[55:32], 8'h0};
        @(posedge clk);
        rx_tvalid <= 1'b0;
        rx_tlast  <= 1'b0;
        rx_tkeep  <= 8'h00;
        rx_tdata  <= ~rx_tdata;
      end
    end
  end
  always @(posedge clk)
    sp_cnt <= (rst || !speed_req) ? 5'd0 : sp_cnt + 5'd1;
  assign speed_done = (sp_cnt == 5'd20);
endmodule
`default_nettype wire

// ### verif/root_port_enum_sequencer_tb.sv
// Purpose: Self-checking bench for the enumeration sequencer
// Assumes: Default ROM script and one test BAR
// Notes:   Expected beats queued as mask and value pairs
`timescale 1ns/1ns
`default_nettype none
`include "enum_map.vh"
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp=%h got=%h", n, e, g); end end
module root_port_enum_sequencer_tb;
  logic         clk, rst, link_up, restart, speed_done, speed_req;
  logic         tx_tvalid, tx_tready, tx_tlast, rx_tvalid, rx_tlast;
  logic [63:0]  tx_tdata, rx_tdata;
  logic [7:0]   tx_tkeep, rx_tkeep;
  logic         enum_done, enum_fail, test_passed, test_failed;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, v, seed;
  logic         reg_wr, reg_rd, bad_status, bad_data, first, lax;
  logic [9:0]   cpl_delay;
  logic [255:0] expq[$];
  logic [255:0] cur;
  int           mismatches, samples_checked, i;

  root_port_enum_sequencer #(.RX_PIPE(1)) dut (
    .clk(clk), .rst(rst), .link_up(link_up), .restart(restart),
    .speed_done(speed_done), .speed_req(speed_req),
    .tx_tvalid(tx_tvalid), .tx_tready(tx_tready), .tx_tdata(tx_tdata),
    .tx_tkeep(tx_tkeep), .tx_tlast(tx_tlast), .rx_tvalid(rx_tvalid),
    .rx_tdata(rx_tdata), .rx_tkeep(rx_tkeep), .rx_tlast(rx_tlast),
    .enum_done(enum_done), .enum_fail(enum_fail),
    .test_passed(test_passed), .test_failed(test_failed),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  root_port_model rp (
    .clk(clk), .rst(rst), .tx_tvalid(tx_tvalid), .tx_tready(tx_tready),
    .tx_tdata(tx_tdata), .tx_tlast(tx_tlast), .rx_tvalid(rx_tvalid),
    .rx_tdata(rx_tdata), .rx_tkeep(rx_tkeep), .rx_tlast(rx_tlast),
    .speed_req(speed_req), .speed_done(speed_done),
    .bad_status(bad_status), .bad_data(bad_data), .cpl_delay(cpl_delay));

  // ==========================================================
  // Expected transmit script
  function automatic logic [63:0] hd(logic [7:0] t);
    return {`DEF_SOURCE_ID, 16'h0, t, 24'h0};
  endfunction
  function automatic logic [63:0] cf(logic [31:0] d, logic [9:0] r);
    return {d, `TGT_BUS, 12'h0, r, 2'b0};
  endfunction
  task automatic push_enum();
    logic [63:0] m0, m1;
    m0 = 64'hFFFF0000_FF000000;
    m1 = 64'hFFFFFFFF_FF000FFC;
    expq.push_back({m0, hd(8'h44), m1, cf(32'h10000000, 10'd4)});
    expq.push_back({m0, hd(8'h44), m1, cf(32'h00000006, 10'd1)});
    expq.push_back({m0, hd(8'h04), {32'h0, m1[31:0]}, cf(32'h0, 10'd0)});
    expq.push_back({64'hFFFF00FF_F8000000, hd(8'h30) | 64'h50_00000000,
                    128'h0});
  endtask
  task automatic push_test();
    expq.push_back({64'hFFFFFFFF, 32'h0, `HDR_MEM_WR, {64{1'b1}},
                    `TEST_PATTERN, `BAR0_ADDR});
    expq.push_back({64'hFFFFFFFF, 32'h0, `HDR_MEM_RD, 64'hFFFFFFFF,
                    32'h0, `BAR0_ADDR});
  endtask

  always @(posedge clk) begin
    if (rst) first <= 1'b1;
    else if (tx_tvalid && tx_tready) begin
      first <= tx_tlast;
      if (first) begin
        cur = (expq.size() > 0) ? expq.pop_front() : 256'h0;
        if (!lax && cur === 256'h0) `CHECK("tx count", 1'b0, 1'b1)
        `CHECK("tx head", cur[191:128], tx_tdata & cur[255:192])
      end else if (cur[127:64] !== 64'h0) begin
        `CHECK("tx body", cur[63:0], tx_tdata & cur[127:64])
        cur[127:64] = 64'h0;
      end
    end
  end

  task automatic reg_rw(input logic wr, input logic [3:0] a,
                        input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'hD399;
    rst = 1'b1;
    link_up = 1'b0;
    restart = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_status = 1'b0;
    bad_data = 1'b0;
    lax = 1'b0;
    cpl_delay = 10'd300;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    push_enum();
    push_test();
    repeat (30) @(posedge clk);
    `CHECK("idle", 1'b0, enum_done | speed_req)
    link_up <= 1'b1;
    repeat (60) @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    for (i = 0; i < 5000 && !test_passed && !test_failed; i++) begin
      @(posedge clk);
      cpl_delay <= 10'($random(seed) & 7);
    end
    `CHECK("flags", 4'b1001, {test_passed, test_failed, enum_fail, enum_done})
    `CHECK("left", 0, expq.size())
    reg_rw(1'b0, `ENUM_REG_STAT, 32'h0);
    `CHECK("stat", 5'b01001, v[4:0])
    reg_rw(1'b0, `ENUM_REG_CTRL, 32'h0);
    `CHECK("ctrl", 2'b01, v[1:0])
    reg_rw(1'b1, 4'h8 | (seed[3:0] & 4'h4), $random(seed));
    reg_rw(1'b0, 4'h8, 32'h0);
    `CHECK("hole", 32'h0, v)
    bad_data <= 1'b1;
    push_test();
    reg_rw(1'b1, `ENUM_REG_CTRL, 32'h3);
    for (i = 0; i < 2000 && !test_failed; i++) @(posedge clk);
    `CHECK("retest", 4'b0101, {test_passed, test_failed, enum_fail, enum_done})
    rst <= 1'b1;
    bad_data <= 1'b0;
    bad_status <= 1'b1;
    lax <= 1'b1;
    repeat (6) @(posedge clk);
    expq.delete();
    push_enum();
    while (expq.size() > 1) expq.pop_back();
    rst <= 1'b0;
    for (i = 0; i < 2000 && !enum_done; i++) @(posedge clk);
    repeat (10) @(posedge clk);
    `CHECK("bad cpl", 4'b0111, {test_passed, test_failed, enum_fail, enum_done})
    `CHECK("walk", 0, expq.size())
    final_report();
  end
endmodule
`default_nettype wire
